// ==== src/lfs_encoder.sv ====
// Frame sync encoder: sequences black and window lines, builds word
// slots on the core clock and serialises them on the lane bit clock.
// Assumes a pixel source that always holds the next four pixel words.
`timescale 1ns/1ps
`default_nettype none
module lfs_encoder (
  // Core clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Lane bit clock
  input  wire logic             link_clk_in,
  // Register port
  input  wire logic             reg_wr_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [9:0]       reg_wdata_in,
  output logic      [9:0]       reg_rdata_out,
  // Readout configuration
  input  wire logic             narrow_mode_in,
  input  wire logic [7:0]       black_lines_in,
  input  wire logic [7:0]       line_words_in,
  input  wire logic [9:0]       window_zero_first_row_in,
  input  wire logic [9:0]       window_zero_last_row_in,
  input  wire logic [9:0]       window_one_first_row_in,
  input  wire logic [9:0]       window_one_last_row_in,
  input  wire logic             frame_start_in,
  // Pixel source
  input  wire lfs_pkg::lfs_lanes_t pix_data_in,
  output logic                  pix_take_out,
  // Serial lanes
  output logic [3:0]            data_lane_out,
  output logic                  sync_lane_out,
  output logic                  fwd_clk_out
);

  // Programmable code registers
  logic [9:0] train_reg;
  logic [6:0] marker_reg;
  logic [9:0] black_code_reg;
  logic [9:0] image_code_reg;
  logic [9:0] check_code_reg;
  logic [9:0] trcode_reg;

  // Sequencer state
  lfs_pkg::lfs_state_e state_reg;
  logic [9:0]          row_reg;
  logic [7:0]          cnt_reg;
  logic [7:0]          lines_reg;
  logic                black_reg;
  logic                start_pend_reg;
  logic [2:0]          id_reg;
  logic                first_reg;
  logic                last_reg;
  lfs_pkg::lfs_lanes_t crc_reg;

  // Crossing state
  lfs_pkg::lfs_slot_s  slot_reg;
  lfs_pkg::lfs_slot_s  slot_next;
  logic                req_reg;
  logic                ack_reg;
  logic                ack_s1_reg;
  logic                ack_s2_reg;
  logic                free;
  logic                emit;
  logic                act0;
  logic                act1;
  logic                row_done;

  function automatic logic in_window(input logic [9:0] row,
                                     input logic [9:0] first,
                                     input logic [9:0] last);
    in_window = (row >= first) && (row <= last);
  endfunction

  // Window number word, placed so the narrow drop leaves it in 4:2
  function automatic logic [9:0] id_word(input logic [2:0] id,
                                         input logic narrow);
    id_word = narrow ? (10'({id}) << lfs_pkg::ID_LSB_NARROW)
                     : (10'({id}) << lfs_pkg::ID_LSB_WIDE);
  endfunction

  // Narrow words keep bits 9:2, MSB first on the wire
  function automatic logic [9:0] load_word(input logic [9:0] w,
                                           input logic narrow);
    load_word = narrow ? {w[9:lfs_pkg::DROP], 2'h0} : w;
  endfunction

  // Register writes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      train_reg      <= lfs_pkg::RST_TRAIN;
      marker_reg     <= lfs_pkg::RST_MARKER;
      black_code_reg <= lfs_pkg::RST_BLACK;
      image_code_reg <= lfs_pkg::RST_IMAGE;
      check_code_reg <= lfs_pkg::RST_CHECK;
      trcode_reg     <= lfs_pkg::RST_TRCODE;
    end else if (reg_wr_in) begin
      if (reg_addr_in == lfs_pkg::OFF_TRAIN)
        train_reg <= reg_wdata_in;
      else if (reg_addr_in == lfs_pkg::OFF_MARKER)
        marker_reg <= reg_wdata_in[6:0];
      else if (reg_addr_in == lfs_pkg::OFF_BLACK)
        black_code_reg <= reg_wdata_in;
      else if (reg_addr_in == lfs_pkg::OFF_IMAGE)
        image_code_reg <= reg_wdata_in;
      else if (reg_addr_in == lfs_pkg::OFF_CHECK)
        check_code_reg <= reg_wdata_in;
      else if (reg_addr_in == lfs_pkg::OFF_TRCODE)
        trcode_reg <= reg_wdata_in;
    end
  end

  // Register readback, registered; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (rst_in)
      reg_rdata_out <= 10'h000;
    else if (reg_addr_in == lfs_pkg::OFF_TRAIN)
      reg_rdata_out <= train_reg;
    else if (reg_addr_in == lfs_pkg::OFF_MARKER)
      reg_rdata_out <= {3'h0, marker_reg};
    else if (reg_addr_in == lfs_pkg::OFF_BLACK)
      reg_rdata_out <= black_code_reg;
    else if (reg_addr_in == lfs_pkg::OFF_IMAGE)
      reg_rdata_out <= image_code_reg;
    else if (reg_addr_in == lfs_pkg::OFF_CHECK)
      reg_rdata_out <= check_code_reg;
    else if (reg_addr_in == lfs_pkg::OFF_TRCODE)
      reg_rdata_out <= trcode_reg;
    else if (reg_addr_in == lfs_pkg::OFF_STATUS)
      reg_rdata_out <= row_reg;
    else
      reg_rdata_out <= 10'h000;
  end

  // Window activity of the current row
  assign act0 = in_window(row_reg, window_zero_first_row_in,
                          window_zero_last_row_in);
  assign act1 = in_window(row_reg, window_one_first_row_in,
                          window_one_last_row_in);
  assign row_done = (row_reg == 10'(lfs_pkg::ROWS - 1));

  // A new slot may only be offered once the lane side took the last
  assign free = (ack_s2_reg == req_reg);
  assign emit = free && (state_reg != lfs_pkg::ST_ROW);

  // Slot contents per state
  always_comb begin
    slot_next.narrow = narrow_mode_in;
    for (int i = 0; i < lfs_pkg::LANES; i++)
      slot_next.data[i] = train_reg;
    slot_next.sync = trcode_reg;
    case (state_reg)
      lfs_pkg::ST_BEGIN: begin
        slot_next.sync = {first_reg ? lfs_pkg::TYP_FRAME_BEGIN
                                    : lfs_pkg::TYP_LINE_BEGIN,
                          marker_reg};
      end
      lfs_pkg::ST_END: begin
        slot_next.sync = {last_reg ? lfs_pkg::TYP_FRAME_FINISH
                                   : lfs_pkg::TYP_LINE_FINISH,
                          marker_reg};
      end
      lfs_pkg::ST_BEGIN_ID, lfs_pkg::ST_END_ID: begin
        slot_next.sync = id_word(id_reg, narrow_mode_in);
      end
      lfs_pkg::ST_PIX: begin
        slot_next.data = pix_data_in;
        slot_next.sync = black_reg ? black_code_reg
                                   : image_code_reg;
      end
      lfs_pkg::ST_CRC: begin
        slot_next.data = crc_reg;
        slot_next.sync = check_code_reg;
      end
      default: begin
      end
    endcase
  end

  // Offer slots to the lane side by toggle handshake
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      slot_reg <= '0;
      req_reg  <= 1'b0;
    end else if (emit) begin
      slot_reg <= slot_next;
      req_reg  <= ~req_reg;
    end
  end

  // Acknowledge comes back from the lane clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // Frame request held until the idle sequencer takes it; set wins
  always_ff @(posedge clk_in) begin
    if (rst_in)
      start_pend_reg <= 1'b0;
    else if (frame_start_in)
      start_pend_reg <= 1'b1;
    else if (emit && state_reg == lfs_pkg::ST_IDLE)
      start_pend_reg <= 1'b0;
  end

  // Pixel take strobe, one per pixel slot
  always_ff @(posedge clk_in) begin
    if (rst_in)
      pix_take_out <= 1'b0;
    else
      pix_take_out <= emit && (state_reg == lfs_pkg::ST_PIX);
  end

  // Per-lane line check word; idle and training excluded
  always_ff @(posedge clk_in) begin
    if (rst_in)
      crc_reg <= '0;
    else if (emit && state_reg == lfs_pkg::ST_PIX)
      crc_reg <= crc_reg ^ pix_data_in;
    else if (emit && state_reg == lfs_pkg::ST_CRC)
      crc_reg <= '0;
  end

  // Readout sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= lfs_pkg::ST_IDLE;
      row_reg   <= 10'h000;
      cnt_reg   <= 8'h00;
      lines_reg <= 8'h00;
      black_reg <= 1'b0;
      id_reg    <= 3'h0;
      first_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      case (state_reg)
        lfs_pkg::ST_IDLE: begin
          if (emit && start_pend_reg) begin
            row_reg   <= 10'h000;
            cnt_reg   <= 8'h00;
            lines_reg <= 8'h00;
            black_reg <= (black_lines_in != 8'h00);
            state_reg <= (black_lines_in != 8'h00) ? lfs_pkg::ST_PIX
                                                   : lfs_pkg::ST_ROW;
          end
        end
        lfs_pkg::ST_ROW: begin
          if (act0 || act1) begin
            // Lower window codes suppressed while window one active
            id_reg    <= act1 ? 3'h1 : 3'h0;
            first_reg <= act1 ? (row_reg == window_one_first_row_in)
                              : (row_reg == window_zero_first_row_in);
            last_reg  <= act1 ? (row_reg == window_one_last_row_in)
                              : (row_reg == window_zero_last_row_in);
            state_reg <= lfs_pkg::ST_BEGIN;
          end else if (row_done) begin
            state_reg <= lfs_pkg::ST_IDLE;
          end else begin
            row_reg <= row_reg + 10'h001;
          end
        end
        lfs_pkg::ST_BEGIN: begin
          if (emit)
            state_reg <= lfs_pkg::ST_BEGIN_ID;
        end
        lfs_pkg::ST_BEGIN_ID: begin
          if (emit)
            state_reg <= lfs_pkg::ST_PIX;
        end
        lfs_pkg::ST_PIX: begin
          if (emit) begin
            if (cnt_reg + 8'h01 >= line_words_in) begin
              cnt_reg   <= 8'h00;
              state_reg <= black_reg ? lfs_pkg::ST_CRC
                                     : lfs_pkg::ST_END;
            end else begin
              cnt_reg <= cnt_reg + 8'h01;
            end
          end
        end
        lfs_pkg::ST_END: begin
          if (emit)
            state_reg <= lfs_pkg::ST_END_ID;
        end
        lfs_pkg::ST_END_ID: begin
          if (emit)
            state_reg <= lfs_pkg::ST_CRC;
        end
        lfs_pkg::ST_CRC: begin
          if (emit) begin
            if (black_reg) begin
              if (lines_reg + 8'h01 >= black_lines_in) begin
                black_reg <= 1'b0;
                state_reg <= lfs_pkg::ST_ROW;
              end else begin
                lines_reg <= lines_reg + 8'h01;
                state_reg <= lfs_pkg::ST_PIX;
              end
            end else if (row_done) begin
              state_reg <= lfs_pkg::ST_IDLE;
            end else begin
              row_reg   <= row_reg + 10'h001;
              state_reg <= lfs_pkg::ST_ROW;
            end
          end
        end
        default: state_reg <= lfs_pkg::ST_IDLE;
      endcase
    end
  end

  // Lane clock domain
  logic       lk_rst_s1_reg;
  logic       lk_rst_reg;
  logic       req_s1_reg;
  logic       req_s2_reg;
  logic       cur_narrow_reg;
  logic [3:0] bit_cnt_reg;
  logic [4:0][9:0] shift_reg;
  logic [4:0][9:0] word_next;
  logic       pending;
  logic       boundary;

  // Reset and request brought into the lane clock
  always_ff @(posedge link_clk_in) begin
    lk_rst_s1_reg <= rst_in;
    lk_rst_reg    <= lk_rst_s1_reg;
    req_s1_reg    <= req_reg;
    req_s2_reg    <= req_s1_reg;
  end

  assign pending  = (req_s2_reg != ack_reg);
  assign boundary = (bit_cnt_reg == (cur_narrow_reg ? lfs_pkg::BITS_NARROW
                                                    : lfs_pkg::BITS_WIDE));

  // Next words; without a fresh slot the lanes fall back to training
  generate
    for (genvar i = 0; i < 5; i++) begin : g_lane
      logic [9:0] raw;
      if (i < 4) begin : g_data
        assign raw = pending ? slot_reg.data[i] : lfs_pkg::RST_TRAIN;
      end else begin : g_sync
        assign raw = pending ? slot_reg.sync : lfs_pkg::RST_TRCODE;
      end
      assign word_next[i] = load_word(raw, pending ? slot_reg.narrow
                                                   : cur_narrow_reg);
    end
  endgenerate

  // Serialiser: all five lanes load on the same bit, MSB first
  always_ff @(posedge link_clk_in) begin
    if (lk_rst_reg) begin
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= '0;
      ack_reg        <= 1'b0;
      cur_narrow_reg <= 1'b0;
    end else if (boundary) begin
      bit_cnt_reg <= 4'h0;
      shift_reg   <= word_next;
      if (pending) begin
        ack_reg        <= ~ack_reg;
        cur_narrow_reg <= slot_reg.narrow;
      end
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      for (int i = 0; i < 5; i++)
        shift_reg[i] <= {shift_reg[i][8:0], 1'b0};
    end
  end

  // Lane pins from flops; forwarded clock toggles each bit (both edges)
  always_ff @(posedge link_clk_in) begin
    if (lk_rst_reg) begin
      data_lane_out <= 4'h0;
      sync_lane_out <= 1'b0;
      fwd_clk_out   <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++)
        data_lane_out[i] <= shift_reg[i][9];
      sync_lane_out <= shift_reg[4][9];
      fwd_clk_out   <= ~fwd_clk_out;
    end
  end

endmodule
`default_nettype wire

// ==== src/lfs_pkg.sv ====
// Shared constants and types of the frame sync encoder.
// Assumes a core clock for sequencing and a separate lane bit clock.
package lfs_pkg;
  // Word and lane shape
  localparam int W     = 10;
  localparam int LANES = 4;
  localparam int ROWS  = 1024;
  localparam int DROP  = 2;                  // Low bits dropped when narrow
  localparam logic [3:0] BITS_WIDE   = 4'h9; // Last bit index, 10-bit word
  localparam logic [3:0] BITS_NARROW = 4'h7; // Last bit index, 8-bit word
  // Register offsets
  localparam logic [7:0] OFF_TRAIN  = 8'h82;
  localparam logic [7:0] OFF_MARKER = 8'h83;
  localparam logic [7:0] OFF_BLACK  = 8'h84;
  localparam logic [7:0] OFF_IMAGE  = 8'h85;
  localparam logic [7:0] OFF_CHECK  = 8'h86;
  localparam logic [7:0] OFF_TRCODE = 8'h87;
  localparam logic [7:0] OFF_STATUS = 8'h88;
  // Register reset values
  localparam logic [9:0] RST_TRAIN  = 10'h3a6;
  localparam logic [6:0] RST_MARKER = 7'h2a;
  localparam logic [9:0] RST_BLACK  = 10'h015;
  localparam logic [9:0] RST_IMAGE  = 10'h035;
  localparam logic [9:0] RST_CHECK  = 10'h059;
  localparam logic [9:0] RST_TRCODE = 10'h3a6;
  // Sync word type field, bits 9:7
  localparam logic [2:0] TYP_FRAME_BEGIN  = 3'h5;
  localparam logic [2:0] TYP_FRAME_FINISH = 3'h6;
  localparam logic [2:0] TYP_LINE_BEGIN   = 3'h1;
  localparam logic [2:0] TYP_LINE_FINISH  = 3'h2;
  // Window number field positions
  localparam int ID_LSB_WIDE   = 0;
  localparam int ID_LSB_NARROW = 4;          // Lands on bits 4:2 after drop

  typedef enum logic [3:0] {
    ST_IDLE, ST_ROW, ST_BEGIN, ST_BEGIN_ID, ST_PIX,
    ST_END, ST_END_ID, ST_CRC
  } lfs_state_e;

  typedef logic [LANES-1:0][W-1:0] lfs_lanes_t;

  // One word slot: four data words plus the sync word describing them
  typedef struct packed {
    logic       narrow;
    lfs_lanes_t data;
    logic [W-1:0] sync;
  } lfs_slot_s;
endpackage

// ==== verif/lfs_encoder_assertions.sv ====
// Port checker for the frame sync encoder, bound to lfs_encoder.
// Assumes the core and link clocks are unrelated in phase.
`timescale 1ns/1ps
`default_nettype none
module lfs_encoder_checker (
  // Clocks and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       link_clk_in,
  // Register port
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [9:0] reg_wdata_in,
  input wire logic [9:0] reg_rdata_out,
  // Sequencing and lanes
  input wire logic       frame_start_in,
  input wire logic       pix_take_out,
  input wire logic       fwd_clk_out
);
  logic       started_reg;
  logic [2:0] lcnt_reg;
  // Frame requested since reset; no pixel may move before it
  always_ff @(posedge clk_in) begin
    if (rst_in) started_reg <= 1'b0;
    else if (frame_start_in) started_reg <= 1'b1;
  end
  // Link edges since release; the link side sees reset two flops late
  always_ff @(posedge link_clk_in) begin
    if (rst_in) lcnt_reg <= 3'h0;
    else if (lcnt_reg != 3'h7) lcnt_reg <= lcnt_reg + 3'h1;
  end
  a_marker_readback: assert property (@(posedge clk_in)
    disable iff (rst_in) reg_wr_in && reg_addr_in == lfs_pkg::OFF_MARKER
    ##1 !reg_wr_in && reg_addr_in == lfs_pkg::OFF_MARKER
    |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 10'h07f))
    else $error("marker readback wrong");
  a_marker_top_zero: assert property (@(posedge clk_in)
    disable iff (rst_in) reg_addr_in == lfs_pkg::OFF_MARKER
    |=> reg_rdata_out[9:7] == 3'h0) else $error("marker top bits set");
  // Class codes at three offsets in a row
  for (genvar i = 0; i < 3; i++) begin : g_code
    localparam logic [7:0] A = lfs_pkg::OFF_BLACK + 8'(i);
    a_code_readback: assert property (@(posedge clk_in)
      disable iff (rst_in) reg_wr_in && reg_addr_in == A
      ##1 !reg_wr_in && reg_addr_in == A
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("class code readback wrong");
  end
  // Data training word and sync training code
  for (genvar i = 0; i < 2; i++) begin : g_train
    localparam logic [7:0] A = lfs_pkg::OFF_TRAIN + 8'(5 * i);
    a_train_readback: assert property (@(posedge clk_in)
      disable iff (rst_in) reg_wr_in && reg_addr_in == A
      ##1 !reg_wr_in && reg_addr_in == A
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("training readback wrong");
  end
  a_rdata_stands: assert property (@(posedge clk_in)
    disable iff (rst_in) !reg_wr_in && !$past(reg_wr_in) && !$past(rst_in)
    && $stable(reg_addr_in) && reg_addr_in != lfs_pkg::OFF_STATUS
    |=> $stable(reg_rdata_out)) else $error("readback drifted");
  a_no_early_take: assert property (@(posedge clk_in)
    disable iff (rst_in) !started_reg |-> !pix_take_out)
    else $error("pixel taken before frame start");
  a_take_gap: assert property (@(posedge clk_in)
    disable iff (rst_in) pix_take_out |=> !pix_take_out [*8])
    else $error("pixel takes closer than one word slot");
  a_fwd_toggle: assert property (@(posedge link_clk_in)
    disable iff (lcnt_reg < 3'h5) fwd_clk_out != $past(fwd_clk_out))
    else $error("forwarded clock missed a toggle");
endmodule
bind lfs_encoder lfs_encoder_checker u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
  .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .frame_start_in(frame_start_in), .pix_take_out(pix_take_out),
  .fwd_clk_out(fwd_clk_out)
);
`default_nettype wire

// ==== verif/lfs_host_model.sv ====
// Host deserializer model: rebuilds word slots from the serial lanes.
// Assumes MSB first words and the bench lane clock.
`timescale 1ns/1ps
`default_nettype none
module lfs_host_model (
  // Lane clock and word mode
  input  wire logic           link_clk_in,
  input  wire logic           narrow_in,
  // Serial lanes
  input  wire logic [3:0]     data_lane_in,
  input  wire logic           sync_lane_in,
  // Recovered slot
  output logic                word_stb_out,
  output logic [9:0]          sync_word_out,
  output lfs_pkg::lfs_lanes_t data_word_out
);
  logic [9:0]          sh_s = 10'h000;
  lfs_pkg::lfs_lanes_t sh_d = '0;
  logic                lock = 1'b0;
  logic                was_nar = 1'b0;
  logic                hit = 1'b0;
  logic                fire;
  int                  cnt = 0;
  int                  len;
  logic [9:0]          msk;
  logic [9:0]          trn;
  initial word_stb_out = 1'b0;
  // Sample mid-bit; alignment needs two training matches one word
  // apart, so a wide word still in flight cannot fake a narrow lock
  always @(negedge link_clk_in) begin
    len = narrow_in ? 8 : 10;
    msk = narrow_in ? 10'h0ff : 10'h3ff;
    trn = lfs_pkg::RST_TRCODE >> (narrow_in ? 2 : 0);
    sh_s = {sh_s[8:0], sync_lane_in};
    for (int i = 0; i < 4; i++) sh_d[i] = {sh_d[i][8:0], data_lane_in[i]};
    if (narrow_in != was_nar) begin
      lock = 1'b0;
      hit = 1'b0;
    end
    was_nar = narrow_in;
    cnt++;
    if (!lock && (sh_s & msk) == trn) begin
      lock = hit && (cnt == len);
      hit = 1'b1;
      cnt = lock ? len : 0;
    end
    fire = lock && (cnt >= len);
    word_stb_out <= fire;
    if (fire) begin
      cnt = 0;
      sync_word_out <= sh_s & msk;
      for (int i = 0; i < 4; i++) data_word_out[i] <= sh_d[i] & msk;
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_lfs_encoder.sv ====
// Self-checking bench for the frame sync encoder.
// Assumes the host model recovers word slots from the lanes.
`timescale 1ns/1ps
`default_nettype none
module tb_lfs_encoder;
  logic                clk_in = 1'b0;
  logic                lclk = 1'b0;
  logic                rst_in = 1'b1;
  logic                wr = 1'b0;
  logic [7:0]          addr = 8'h00;
  logic [9:0]          wdata = 10'h000;
  logic [9:0]          rdata;
  logic                nar = 1'b0;
  logic                fs = 1'b0;
  logic                mon = 1'b0;
  logic [7:0]          bl = 8'h02;
  logic [7:0]          lw = 8'h02;
  logic                take;
  logic                stb;
  logic                sync_l;
  logic [3:0]          dl;
  logic [9:0]          gsync;
  logic [9:0]          v;
  lfs_pkg::lfs_lanes_t pix;
  lfs_pkg::lfs_lanes_t gdata;
  int                  pix_cnt = 0;
  int                  err_total = 0;
  int                  num_checks = 0;
  logic [9:0]          es[$];
  logic [9:0]          gs[$];
  lfs_pkg::lfs_lanes_t ed[$];
  lfs_pkg::lfs_lanes_t gd[$];
  bit                  ek[$];
  logic [9:0]          rv[6] = '{lfs_pkg::RST_TRAIN, 10'(lfs_pkg::RST_MARKER),
    lfs_pkg::RST_BLACK, lfs_pkg::RST_IMAGE, lfs_pkg::RST_CHECK,
    lfs_pkg::RST_TRCODE};
  // Clocks; link rate kept the same in narrow mode
  always #5 clk_in = ~clk_in;
  initial begin
    #7;
    forever #16 lclk = ~lclk;
  end
  // Pixel source steps after each take; lane i tagged in low bits
  always @(negedge clk_in) if (take) pix_cnt <= pix_cnt + 1;
  always_comb for (int i = 0; i < 4; i++) pix[i] = {pix_cnt[7:0], 2'(i)};
  lfs_encoder u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .link_clk_in(lclk),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .narrow_mode_in(nar), .black_lines_in(bl),
    .line_words_in(lw), .window_zero_first_row_in(10'h003),
    .window_zero_last_row_in(10'h005), .window_one_first_row_in(10'h004),
    .window_one_last_row_in(10'h006), .frame_start_in(fs),
    .pix_data_in(pix), .pix_take_out(take), .data_lane_out(dl),
    .sync_lane_out(sync_l), .fwd_clk_out()
  );
  lfs_host_model u_host (
    .link_clk_in(lclk), .narrow_in(nar), .data_lane_in(dl),
    .sync_lane_in(sync_l), .word_stb_out(stb), .sync_word_out(gsync),
    .data_word_out(gdata)
  );
  function automatic logic [9:0] nw(input logic [9:0] x);
    return nar ? {2'h0, x[9:2]} : x;
  endfunction
  function automatic lfs_pkg::lfs_lanes_t nl(input lfs_pkg::lfs_lanes_t x);
    for (int i = 0; i < 4; i++) x[i] = nw(x[i]);
    return x;
  endfunction
  task automatic chk10(input logic [9:0] g, input logic [9:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkd(input lfs_pkg::lfs_lanes_t g, lfs_pkg::lfs_lanes_t e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [9:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [9:0] d);
    @(negedge clk_in);
    addr = a;
    @(negedge clk_in);
    d = rdata;
  endtask
  task automatic add(input logic [9:0] s, lfs_pkg::lfs_lanes_t d, bit k);
    es.push_back(s);
    ed.push_back(d);
    ek.push_back(k);
  endtask
  // Expected slots: black lines, then rows 3..6 where window 1 wins
  task automatic build(input logic [6:0] mk);
    lfs_pkg::lfs_lanes_t x;
    lfs_pkg::lfs_lanes_t p;
    logic [9:0] id;
    logic [2:0] t0;
    logic [2:0] t1;
    int n;
    int row;
    n = pix_cnt;
    for (int r = 0; r < int'(bl) + 4; r++) begin
      row = r - int'(bl) + 3;
      id = (row >= 4) ? (nar ? 10'h004 : 10'h001) : 10'h000;
      t0 = (row < 5) ? lfs_pkg::TYP_FRAME_BEGIN : lfs_pkg::TYP_LINE_BEGIN;
      t1 = (row == 6) ? lfs_pkg::TYP_FRAME_FINISH : lfs_pkg::TYP_LINE_FINISH;
      x = '0;
      if (row >= 3) add(nw({t0, mk}), x, 0);
      if (row >= 3) add(id, x, 0);
      for (int j = 0; j < int'(lw); j++) begin
        for (int i = 0; i < 4; i++) p[i] = {n[7:0], 2'(i)};
        x = x ^ p;
        n++;
        add(nw(row < 3 ? lfs_pkg::RST_BLACK : lfs_pkg::RST_IMAGE), nl(p), 1);
      end
      if (row >= 3) add(nw({t1, mk}), '0, 0);
      if (row >= 3) add(id, '0, 0);
      add(nw(lfs_pkg::RST_CHECK), nl(x), 1);
    end
  endtask
  // Idle slots checked at once, others queued; off for the code pokes before the first run
  always @(negedge stb) if (mon) begin
    if (gsync === nw(lfs_pkg::RST_TRCODE))
      chkd(gdata, nl({4{lfs_pkg::RST_TRAIN}}));
    else begin
      gs.push_back(gsync);
      gd.push_back(gdata);
    end
  end
  task automatic run(input logic [6:0] mk);
    int t;
    // Old-mode and old-code words drain and the host relocks first
    repeat (400) @(negedge clk_in);
    mon = 1'b1;
    build(mk);
    gs.delete();
    gd.delete();
    @(negedge clk_in) fs = 1'b1;
    @(negedge clk_in) fs = 1'b0;
    t = 0;
    while (gs.size() < es.size() && t < 80000) begin
      @(posedge clk_in);
      t++;
    end
    chk10(10'(gs.size()), 10'(es.size()));
    foreach (es[i]) if (i < gs.size()) begin
      chk10(gs[i], es[i]);
      if (ek[i]) chkd(gd[i], ed[i]);
    end
    es.delete();
    ed.delete();
    ek.delete();
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_reg(8'h82 + 8'(i), v);
      chk10(v, rv[i]);
      wr_reg(8'h82 + 8'(i), 10'h2c5 ^ 10'(i));
      rd_reg(8'h82 + 8'(i), v);
      chk10(v, (10'h2c5 ^ 10'(i)) & (i == 1 ? 10'h07f : 10'h3ff));
      wr_reg(8'h82 + 8'(i), rv[i]);
    end
    wr_reg(8'h89, 10'h3ff);
    rd_reg(8'h89, v);
    chk10(v, 10'h000);
    run(7'h2a);
    // Row scan runs on to the top row after the last window line
    repeat (1100) @(negedge clk_in);
    rd_reg(lfs_pkg::OFF_STATUS, v);
    chk10(v, 10'(lfs_pkg::ROWS - 1));
    wr_reg(lfs_pkg::OFF_MARKER, 10'h055);
    @(negedge clk_in);
    nar = 1'b1;
    bl = 8'h01;
    lw = 8'h03;
    run(7'h55);
    finish_test;
  end
  // Hang guard sized well beyond two full frame scans
  initial begin
    repeat (95000) @(posedge clk_in);
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
